// file: hw/cawd_cfg.svh
`ifndef CAWD_CFG_SVH
`define CAWD_CFG_SVH
// register byte addresses
`define CAWD_OFF_CTRL      12'h000
`define CAWD_OFF_MODE      12'h004
`define CAWD_OFF_CNT_LO    12'h008
`define CAWD_OFF_CNT_HI    12'h00C
`define CAWD_OFF_MM0       12'h010
`define CAWD_OFF_CMPL0     12'h020
`define CAWD_OFF_CMPH0     12'h030
// array mode register fields
`define CAWD_MD_IDLE       7
`define CAWD_MD_WDON       6
`define CAWD_MD_WATCHDOG_LOCK      5
`define CAWD_MD_TB_HI      3
`define CAWD_MD_TB_LO      1
`define CAWD_MD_RESET      8'h40
// control register fields
`define CAWD_CN_RUN        6
// module mode fields
`define CAWD_MM_WIDE       7
`define CAWD_MM_CMP        6
`define CAWD_MM_MAT        3
`define CAWD_MM_TOG        2
`define CAWD_MM_PWM        1
`define CAWD_MM_SWTIMER    8'h48
// timebase divisors
`define CAWD_DIV12         4'd11
`define CAWD_DIV4          4'd3
`define CAWD_DIV8          4'd7
`endif

// file: hw/cawd_pkg.sv
`default_nettype none
package cawd_pkg;
    typedef enum logic [2:0] {
        CAWD_TB_DIV12,
        CAWD_TB_DIV4,
        CAWD_TB_T0OVF,
        CAWD_TB_EXTFALL,
        CAWD_TB_SYSCLK,
        CAWD_TB_EXTDIV8,
        CAWD_TB_RSV6,
        CAWD_TB_RSV7
    } cawd_tb_t;
    typedef struct packed {
        logic       wide;
        logic       cmp;
        logic       mat;
        logic       tog;
        logic       pwm;
    } cawd_mode_t;
    typedef struct packed {
        logic       tick;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic       lo_wrap;
        logic       hi_wrap;
    } cawd_cnt_t;
endpackage
`default_nettype wire

// file: hw/cawd_module.sv
`include "cawd_cfg.svh"
`default_nettype none
// one compare module: frequency output, 8/16-bit pwm, match flag
module cawd_module
    import cawd_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // counter and module mode
    input  wire cawd_cnt_t  cnt,
    input  wire cawd_mode_t mode,
    // compare register writes
    input  wire logic       wr_lo,
    input  wire logic       wr_hi,
    input  wire logic [7:0] wdata,
    input  wire logic       wd_reload,
    input  wire logic [7:0] wd_value,
    // state
    output logic [7:0]      cmp_lo_r,
    output logic [7:0]      cmp_hi_r,
    output logic            cmp_en_r,
    output logic            match,
    output logic            pin_r
);
    logic [7:0] cmp_lo_nxt;
    logic [7:0] cmp_hi_nxt;
    logic       pin_nxt;
    wire        fout   = cmp_en_r & mode.tog & mode.pwm;
    wire        pwm8   = mode.pwm & ~mode.tog & ~mode.wide;
    wire        pwm16  = mode.pwm & ~mode.tog & mode.wide;
    wire        lo_eq  = cnt.cnt_lo == cmp_lo_r;
    wire        hi_eq  = cnt.cnt_hi == cmp_hi_r;
    wire        eq8    = cnt.tick & lo_eq;
    wire        eq16   = cnt.tick & lo_eq & hi_eq;
    wire        ovf8   = cnt.tick & cnt.lo_wrap;
    wire        ovf16  = ovf8 & cnt.hi_wrap;
    // pin rises as the count reaches compare: high from compare to wrap
    wire        set8   = cnt.tick &
                         (8'(cnt.cnt_lo + 8'h01) == cmp_lo_r);
    wire        set16  = cnt.tick &
                         (16'({cnt.cnt_hi, cnt.cnt_lo} + 16'h0001) ==
                          {cmp_hi_r, cmp_lo_r});

    assign match = cmp_en_r & (mode.pwm & ~mode.wide ? eq8 : eq16);

    always_comb
    begin
        cmp_lo_nxt = cmp_lo_r;
        cmp_hi_nxt = cmp_hi_r;
        pin_nxt    = pin_r;
        if (fout && eq8)
        begin
            pin_nxt    = ~pin_r;
            cmp_lo_nxt = cmp_lo_r + cmp_hi_r;
        end
        else if (pwm8)
        begin
            if (!cmp_en_r)
                pin_nxt = 1'b0;
            else if (ovf8)
                pin_nxt = (cmp_hi_r == 8'h00);
            else if (set8)
                pin_nxt = 1'b1;
            if (ovf8)
                cmp_lo_nxt = cmp_hi_r;
        end
        else if (pwm16)
        begin
            if (!cmp_en_r)
                pin_nxt = 1'b0;
            else if (ovf16)
                pin_nxt = ({cmp_hi_r, cmp_lo_r} == 16'h0000);
            else if (set16)
                pin_nxt = 1'b1;
        end
        if (wr_lo)
            cmp_lo_nxt = wdata;
        if (wd_reload)
            cmp_hi_nxt = wd_value;
        else if (wr_hi)
            cmp_hi_nxt = wdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_lo_r <= 8'h00;
            cmp_hi_r <= 8'h00;
            cmp_en_r <= 1'b0;
            pin_r    <= 1'b0;
        end
        else
        begin
            cmp_lo_r <= cmp_lo_nxt;
            cmp_hi_r <= cmp_hi_nxt;
            pin_r    <= pin_nxt;
            if (wr_hi || wd_reload)
                cmp_en_r <= 1'b1;
            else if (wr_lo)
                cmp_en_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hw/cawd_top.sv
// Notes on behaviour
// - frequency mode toggles pin every high-byte clocks
// - high byte zero means 256 clock half-period
// - on low match toggle, add high to low
// - 8-bit pwm: set on match, clear overflow
// - low byte wrap reloads low from high
// - 8-bit duty is (256 - high)/256
// - compare disabled gives constant zero output in pwm modes; frequency mode holds pin
// - low write clears, high write sets enable
// - 16-bit pwm: set on match, clear overflow
// - enable, pwm and wide select 16-bit pwm
// - zero gives full duty, FFFF minimal
// - watchdog_on turns module 2 into watchdog
// - watchdog freezes counter, timebase, idle, mode2
// - run writes ignored, run reads software value
// - module 2 high write loads count plus offset
// - low wrap with high match resets system
// - writing module 2 flag forces reset
// - on or lock enables; lock holds until reset
// - reset enables watchdog, timebase divide twelve
// - timebase select encodes six counter clock sources
// - wide select picks 8 or 16-bit pwm
`include "cawd_cfg.svh"
`default_nettype none
module cawd_top
    import cawd_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // timebase sources and cpu idle input
    input  wire logic        timer0_ovf,
    input  wire logic        ext_count_in,
    input  wire logic        ext_osc_tick,
    input  wire logic        cpu_idle,
    // module outputs and reset
    output logic [2:0]       module_output_pin,
    output logic             watchdog_reset_r
);
    // ==========================================================
    // registers
    // ==========================================================
    logic [7:0]  md_r;
    logic        run_r;
    logic [2:0]  flag_r;
    logic [7:0]  cnt_lo_r;
    logic [7:0]  cnt_hi_r;
    logic [7:0]  mm_r [3];
    logic [3:0]  div_r;
    logic [2:0]  ext_div_r;
    logic        ext_d_r;
    logic [31:0] rdata_nxt;
    logic [7:0]  cmp_lo [3];
    logic [7:0]  cmp_hi [3];
    logic [2:0]  cmp_en;
    logic [2:0]  match;
    logic [2:0]  pin;
    cawd_cnt_t   cnt;

    // ==========================================================
    // decode
    // ==========================================================
    wire        acc     = psel & penable;
    wire        wr      = acc & pwrite;
    wire [11:0] a       = paddr;
    wire [7:0]  wd8     = pwdata[7:0];
    wire        sel_cn  = a == `CAWD_OFF_CTRL;
    wire        sel_md  = a == `CAWD_OFF_MODE;
    wire        sel_cl  = a == `CAWD_OFF_CNT_LO;
    wire        sel_ch  = a == `CAWD_OFF_CNT_HI;
    wire        wd_en   = md_r[`CAWD_MD_WDON] | md_r[`CAWD_MD_WATCHDOG_LOCK];
    wire        idle_hold = md_r[`CAWD_MD_IDLE] & cpu_idle;
    wire        running = (run_r | wd_en) & ~idle_hold;
    wire cawd_tb_t tb   = cawd_tb_t'(md_r[`CAWD_MD_TB_HI:`CAWD_MD_TB_LO]);
    wire        ext_fall = ext_d_r & ~ext_count_in;
    logic       tick_src;

    // timebase selection
    always_comb
    begin
        case (tb)
            CAWD_TB_DIV12:   tick_src = div_r == `CAWD_DIV12;
            CAWD_TB_DIV4:    tick_src = div_r[1:0] == `CAWD_DIV4;
            CAWD_TB_T0OVF:   tick_src = timer0_ovf;
            CAWD_TB_EXTFALL: tick_src = ext_fall;
            CAWD_TB_SYSCLK:  tick_src = 1'b1;
            CAWD_TB_EXTDIV8: tick_src = ext_osc_tick &&
                                        ext_div_r == `CAWD_DIV8;
            default:         tick_src = 1'b0;
        endcase
    end

    assign cnt.tick    = tick_src & running;
    assign cnt.cnt_lo  = cnt_lo_r;
    assign cnt.cnt_hi  = cnt_hi_r;
    assign cnt.lo_wrap = cnt_lo_r == 8'hFF;
    assign cnt.hi_wrap = cnt_hi_r == 8'hFF;

    wire wd_hit  = wd_en && cnt.tick && cnt.lo_wrap
                   && cmp_hi[2] == cnt_hi_r;
    wire wd_kick = wd_en && wr && sel_cn && wd8[2];

    // ==========================================================
    // compare modules
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_mod
            wire        wr_lo = wr && a == `CAWD_OFF_CMPL0 + 12'(4 * g);
            wire        wr_hi = wr && a == `CAWD_OFF_CMPH0 + 12'(4 * g);
            wire        is_wd = (g == 2) && wd_en;
            wire [7:0]  mmv   = is_wd ? `CAWD_MM_SWTIMER : mm_r[g];
            cawd_mode_t mode;
            assign mode.wide = mmv[`CAWD_MM_WIDE];
            assign mode.cmp  = mmv[`CAWD_MM_CMP];
            assign mode.mat  = mmv[`CAWD_MM_MAT];
            assign mode.tog  = mmv[`CAWD_MM_TOG];
            assign mode.pwm  = mmv[`CAWD_MM_PWM];
            cawd_module u_mod (
                .pclk      (pclk),
                .presetn   (presetn),
                .cnt       (cnt),
                .mode      (mode),
                .wr_lo     (wr_lo),
                .wr_hi     (wr_hi && !is_wd),
                .wdata     (wd8),
                .wd_reload (wr_hi && is_wd),
                .wd_value  (8'(cnt_hi_r + cmp_lo[g])),
                .cmp_lo_r  (cmp_lo[g]),
                .cmp_hi_r  (cmp_hi[g]),
                .cmp_en_r  (cmp_en[g]),
                .match     (match[g]),
                .pin_r     (pin[g])
            );
        end
    endgenerate

    // ==========================================================
    // read mux
    // ==========================================================
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (sel_cn)
            rdata_nxt[7:0] = {1'b0, run_r, 3'b000, flag_r};
        else if (sel_md)
            rdata_nxt[7:0] = md_r;
        else if (sel_cl)
            rdata_nxt[7:0] = cnt_lo_r;
        else if (sel_ch)
            rdata_nxt[7:0] = cnt_hi_r;
        for (int i = 0; i < 3; i++)
        begin
            if (a == `CAWD_OFF_MM0 + 12'(4 * i))
                rdata_nxt[7:0] = {mm_r[i][7:1] & 7'h7F, mm_r[i][0]} &
                                 {1'b1, cmp_en[i] | 1'b0, 6'h3F} |
                                 {1'b0, cmp_en[i], 6'h00};
            if (a == `CAWD_OFF_CMPL0 + 12'(4 * i))
                rdata_nxt[7:0] = cmp_lo[i];
            if (a == `CAWD_OFF_CMPH0 + 12'(4 * i))
                rdata_nxt[7:0] = cmp_hi[i];
        end
    end

    wire mapped = sel_cn | sel_md | sel_cl | sel_ch |
                  (a[11:6] == 6'h00 && a[1:0] == 2'b00 &&
                   a[5:2] >= 4'h4 && a[5:2] != 4'h7 &&
                   a[5:2] != 4'hB && a[5:2] <= 4'hE);

    // ==========================================================
    // apb answer: one wait-free access phase
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_nxt : prdata;
        end
    end

    // ==========================================================
    // control, counter, flags
    // ==========================================================
    wire wr_ok = wr && pready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            md_r     <= `CAWD_MD_RESET;
            run_r    <= 1'b0;
            cnt_lo_r <= 8'h00;
            cnt_hi_r <= 8'h00;
            flag_r   <= 3'b000;
            div_r    <= 4'h0;
            ext_div_r <= 3'h0;
            ext_d_r  <= 1'b1;
            watchdog_reset_r <= 1'b0;
            module_output_pin <= 3'b000;
            for (int i = 0; i < 3; i++)
                mm_r[i] <= 8'h00;
        end
        else
        begin
            div_r   <= (div_r == `CAWD_DIV12) ? 4'h0 : div_r + 4'h1;
            ext_d_r <= ext_count_in;
            if (ext_osc_tick)
                ext_div_r <= ext_div_r + 3'h1;
            module_output_pin <= pin;
            watchdog_reset_r  <= wd_hit | wd_kick;
            for (int i = 0; i < 3; i++)
            begin
                if (match[i])
                    flag_r[i] <= 1'b1;
                else if (wr_ok && sel_cn && !wd8[i])
                    flag_r[i] <= 1'b0;
                if (wr_ok && a == `CAWD_OFF_MM0 + 12'(4 * i)
                    && !(i == 2 && wd_en))
                    mm_r[i] <= wd8;
            end
            if (wr_ok && sel_cn)
                run_r <= wd8[`CAWD_CN_RUN];
            if (wr_ok && sel_md)
            begin
                if (!wd_en)
                    md_r <= wd8 & 8'hEF;
                else if (!md_r[`CAWD_MD_WATCHDOG_LOCK])
                begin
                    md_r[`CAWD_MD_WDON]  <= wd8[`CAWD_MD_WDON];
                    md_r[`CAWD_MD_WATCHDOG_LOCK] <= wd8[`CAWD_MD_WATCHDOG_LOCK];
                end
            end
            if (wr_ok && sel_cl && !wd_en)
                cnt_lo_r <= wd8;
            else if (cnt.tick)
                cnt_lo_r <= cnt_lo_r + 8'h01;
            if (wr_ok && sel_ch && !wd_en)
                cnt_hi_r <= wd8;
            else if (cnt.tick && cnt.lo_wrap)
                cnt_hi_r <= cnt_hi_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: tb/cawd_pin_probe.sv
`default_nettype none
// ====================
// pin run-length probe
module cawd_pin_probe (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // observed pin
    input  wire logic pin,
    // last complete high and low runs
    output var  int   hi_len,
    output var  int   lo_len
);
    timeunit 1ns;
    timeprecision 100ps;
    int   run;
    logic prev;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= 0;
            prev <= 1'b0;
            hi_len <= 0;
            lo_len <= 0;
        end
        else
        begin
            prev <= pin;
            if (pin !== prev)
            begin
                run <= 1;
                if (prev)
                    hi_len <= run;
                else
                    lo_len <= run;
            end
            else
                run <= run + 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/cawd_top_sva.sv
`default_nettype none
module cawd_top_sva (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // outputs
    input wire logic [2:0]  module_output_pin,
    input wire logic        watchdog_reset_r
);
    logic [11:0] cyc_r;
    logic        wr_r;
    logic        md_r;
    wire         acc = psel && penable && pready && pwrite;
    // ====================
    // history since reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cyc_r <= 12'h000;
            wr_r <= 1'b0;
            md_r <= 1'b0;
        end
        else
        begin
            if (cyc_r != 12'hFFF)
                cyc_r <= cyc_r + 12'h001;
            if (acc)
                wr_r <= 1'b1;
            if (acc && paddr == 12'h004)
                md_r <= 1'b1;
        end
    end
    // ====================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 0)
        else $error("read data upper bits set");
    wd_pulse_a: assert property (watchdog_reset_r |=> !watchdog_reset_r)
        else $error("watchdog reset longer than a cycle");
    wd_force_a: assert property (acc && paddr == 12'h000 && pwdata[2]
        && !md_r |-> ##[1:2] watchdog_reset_r)
        else $error("flag write did not force reset");
    wd_early_a: assert property (!wr_r && cyc_r < 12'd3000
        |-> !watchdog_reset_r)
        else $error("watchdog reset too early");
    pin_idle_a: assert property (!wr_r |-> module_output_pin == 3'b000)
        else $error("pin active before setup");
    cover property (watchdog_reset_r);
    cover property (pslverr);
    cover property ($rose(module_output_pin[0]));
endmodule
bind cawd_top cawd_top_sva u_cawd_top_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .module_output_pin(module_output_pin),
    .watchdog_reset_r(watchdog_reset_r));
`default_nettype wire

// file: tb/counter_array_pwm_watchdog_bench.sv
`default_nettype none
module counter_array_pwm_watchdog_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  pin;
    logic        wd_rst;
    logic [31:0] q;
    logic [7:0]  e8;
    logic        err_seen;
    int          errors = 0;
    int          comparisons = 0;
    int          n;
    int          hi_len;
    int          lo_len;
    cawd_top u_cawd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .timer0_ovf(1'b0), .ext_count_in(1'b0), .ext_osc_tick(1'b0),
        .cpu_idle(1'b0), .module_output_pin(pin), .watchdog_reset_r(wd_rst));
    cawd_pin_probe u_cawd_pin_probe (.pclk(pclk), .presetn(presetn),
        .pin(pin[0]), .hi_len(hi_len), .lo_len(lo_len));
    always #12.5 pclk = ~pclk;
    // ====================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16)
            errors++;
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic wait_wd(input int lim);
        n = 0;
        while (wd_rst !== 1'b1 && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ====================
    // tests
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h004, 32'h40);
        rc(12'h028, 32'h00);
        apb(1'b0, 12'h000, 32'h0);
        chk("run", 1'b0, q[6]);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("slverr", 1'b1, err_seen);
        apb(1'b1, 12'h000, 32'h04);
        wait_wd(4);
        chk("wd force", 1'b1, wd_rst);
        do_reset;
        apb(1'b1, 12'h004, 32'h42);
        rc(12'h004, 32'h40);
        apb(1'b1, 12'h018, 32'h02);
        rc(12'h018, 32'h00);
        apb(1'b1, 12'h00C, 32'h80);
        rc(12'h00C, 32'h00);
        apb(1'b1, 12'h028, 32'h05);
        apb(1'b0, 12'h00C, 32'h0);
        e8 = q[7:0] + 8'h05;
        apb(1'b1, 12'h038, 32'hAA);
        rc(12'h038, {24'h0, e8});
        do_reset;
        wait_wd(4000);
        chk("wd timeout", 1'b1, n >= 3060 && n <= 3100);
        do_reset;
        apb(1'b1, 12'h004, 32'h00);
        apb(1'b1, 12'h004, 32'h08);
        rc(12'h004, 32'h08);
        apb(1'b1, 12'h010, 32'h46);
        apb(1'b1, 12'h020, 32'h00);
        apb(1'b1, 12'h030, 32'h04);
        apb(1'b1, 12'h000, 32'h40);
        repeat (100) @(posedge pclk);
        chk("half hi", 4, hi_len);
        chk("half lo", 4, lo_len);
        apb(1'b1, 12'h030, 32'h00);
        repeat (1100) @(posedge pclk);
        chk("half max", 256, hi_len);
        apb(1'b1, 12'h010, 32'h42);
        apb(1'b1, 12'h020, 32'h10);
        rc(12'h010, 32'h02);
        repeat (600) @(posedge pclk);
        chk("pin off", 1'b0, pin[0]);
        apb(1'b1, 12'h030, 32'h40);
        rc(12'h010, 32'h42);
        repeat (600) @(posedge pclk);
        chk("pwm hi", 192, hi_len);
        chk("pwm lo", 64, lo_len);
        rc(12'h020, 32'h40);
        apb(1'b1, 12'h030, 32'hFF);
        repeat (600) @(posedge pclk);
        chk("pwm min", 1, hi_len);
        apb(1'b1, 12'h010, 32'hCB);
        apb(1'b1, 12'h020, 32'h80);
        apb(1'b1, 12'h030, 32'hFF);
        apb(1'b1, 12'h008, 32'h00);
        apb(1'b1, 12'h00C, 32'hFE);
        repeat (700) @(posedge pclk);
        chk("wide hi", 128, hi_len);
        rc(12'h000, 32'h41);
        apb(1'b1, 12'h020, 32'hFF);
        apb(1'b1, 12'h030, 32'hFF);
        apb(1'b1, 12'h00C, 32'hFE);
        repeat (700) @(posedge pclk);
        chk("wide min", 1, hi_len);
        apb(1'b1, 12'h004, 32'h28);
        apb(1'b1, 12'h004, 32'h00);
        rc(12'h004, 32'h28);
        finish_test;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
